/* File: ccfc_top.sv */
// compensation control register, status flags and coefficient bank behind apb
// assumes analog front end gives done and out-of-range pulses on pclk
//
// Behaviour
// - coefficients sixteen-bit sign magnitude
// - coefficient reset values symmetric set
// - control register full sixteen-bit access only
// - control at 0xA0 in both windows
// - field updates only with mask bit set
// - mask bit assignment per field
// - bandgap select encoding, resets to two
// - input short bit shorts amplifier inputs
// - start bit launches offset calibration only while current channel enabled
// - start stays set, rearm needs zero write
// - voltage diag routes reference to voltage
// - current diag routes reference to current
// - irq enable gates calibration request interrupt
// - done flag set on finish of a running calibration, w1c
// - request flag set on out-of-range, w1c
`timescale 1ns/10ps
module ccfc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        offset_cal_finished,
    input  wire logic        temp_out_of_range,
    input  wire logic        current_channel_enable,
    output logic      [1:0]  bandgap_select,
    output logic             amp_input_short,
    output logic             offset_cal_start,
    output logic             voltage_diag_route,
    output logic             current_diag_route,
    output logic             cal_irq,
    output logic             irq,
    output logic      [ccfc_pkg::COEF_W*ccfc_pkg::NUM_COEF-1:0] coef_flat
);
    import ccfc_pkg::*;

    // ********************************
    // address decode
    // ********************************
    logic        in_window;
    logic [11:0] ofs;
    logic        sel_ctl;
    logic        sel_sr;
    logic        sel_coef;
    logic        sel_istat;
    logic        sel_imask;
    logic        mapped;
    logic        full_half;
    logic        bad_width;
    logic        acc;
    logic        wr;
    logic        rd;

    always_comb begin
        in_window = (paddr[11:8] == BLOCK_BASE[11:8]) || (paddr[11:8] == NBLOCK_BASE[11:8]);
        ofs       = {4'h0, paddr[7:0]};
    end
    assign sel_ctl   = in_window && (ofs == ADDR_COMPENSATION_CONTROL);
    assign sel_sr    = in_window && (ofs == ADDR_COMP_SR);
    assign sel_coef  = in_window && (ofs[7:6] == OFS_COEF_BASE[7:6]) && (ofs[1:0] == 2'h0);
    assign sel_istat = in_window && (ofs == OFS_IRQ_STAT);
    assign sel_imask = in_window && (ofs == OFS_IRQ_MASK);
    assign mapped    = sel_ctl | sel_sr | sel_coef | sel_istat | sel_imask;
    assign full_half = (pstrb[1:0] == 2'h3);
    // bytewise writes to the control word are refused
    assign bad_width = sel_ctl && pwrite && !full_half;
    assign acc       = psel && penable;
    assign wr        = acc && pwrite && mapped && !bad_width;
    assign rd        = acc && !pwrite && mapped;
    assign pready    = 1'b1;
    assign pslverr   = acc && (!mapped || bad_width);

    // ********************************
    // compensation control fields
    // ********************************
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic       ctl_wr;
    logic [15:0] wd;
    assign ctl_wr = wr && sel_ctl;
    assign wd     = pwdata[15:0];

    always_comb begin
        ctl_d = ctl_q;
        if (ctl_wr) begin
            if (wd[BIT_BG_M_LO+1]) ctl_d[BIT_BG_LO+1] = wd[BIT_BG_LO+1];
            if (wd[BIT_BG_M_LO])   ctl_d[BIT_BG_LO]   = wd[BIT_BG_LO];
            if (wd[BIT_SHORT_M])   ctl_d[BIT_SHORT]   = wd[BIT_SHORT];
            if (wd[BIT_OCAL_M])    ctl_d[BIT_OCAL]    = wd[BIT_OCAL];
            if (wd[BIT_VOLTAGE_DIAG_ROUTE_M])   ctl_d[BIT_VOLTAGE_DIAG_ROUTE]   = wd[BIT_VOLTAGE_DIAG_ROUTE];
            if (wd[BIT_CURRENT_DIAG_ROUTE_M])   ctl_d[BIT_CURRENT_DIAG_ROUTE]   = wd[BIT_CURRENT_DIAG_ROUTE];
            if (wd[BIT_IRQEN_M])   ctl_d[BIT_IRQEN]   = wd[BIT_IRQEN];
        end
        ctl_d[1] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= CTL_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign bandgap_select     = ctl_q[BIT_BG_LO+1:BIT_BG_LO];
    assign amp_input_short    = ctl_q[BIT_SHORT];
    assign offset_cal_start   = ctl_q[BIT_OCAL];
    assign voltage_diag_route = ctl_q[BIT_VOLTAGE_DIAG_ROUTE];
    assign current_diag_route = ctl_q[BIT_CURRENT_DIAG_ROUTE];

    // ********************************
    // calibration launch pulse
    // ********************************
    logic ocal_prev_q;
    logic ocal_launch;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ocal_prev_q <= 1'b0;
        end else begin
            ocal_prev_q <= ctl_q[BIT_OCAL];
        end
    end
    // rising edge only, so a held start bit never relaunches; no current channel, no calibration
    assign ocal_launch = ctl_q[BIT_OCAL] && !ocal_prev_q && current_channel_enable;

    // calibration in progress; finish counts only while running
    logic busy_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (ocal_launch) begin
            busy_q <= 1'b1;
        end else if (offset_cal_finished) begin
            busy_q <= 1'b0;
        end
    end

    // ********************************
    // status flags, write one clears
    // ********************************
    logic [1:0] sr_set;
    logic [1:0] sr_clr;
    logic [1:0] sr_q;
    assign sr_set = {busy_q && offset_cal_finished, temp_out_of_range};
    assign sr_clr = (wr && sel_sr) ? {wd[BIT_DONE_F], wd[BIT_CALREQ_F]} : 2'h0;

    ccfc_flag_unit #(.N(2)) u_sr (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (sr_set),
        .clr     (sr_clr),
        .flag_q  (sr_q)
    );

    // calibration request interrupt gated by enable
    assign cal_irq = sr_q[0] && ctl_q[BIT_IRQEN];

    // ********************************
    // interrupt status, mask, output
    // ********************************
    logic [1:0] ist_q;
    logic [1:0] imask_q;
    logic       ist_rd;
    assign ist_rd = rd && sel_istat;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= IRQ_RESET;
        end else begin
            ist_q <= (ist_rd ? 2'h0 : ist_q) | sr_set;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= IRQ_RESET;
        end else if (wr && sel_imask) begin
            imask_q <= pwdata[1:0];
        end
    end
    // request event also needs the calibration irq enable
    assign irq = |(ist_q & imask_q & {1'b1, ctl_q[BIT_IRQEN]});

    // ********************************
    // coefficients
    // ********************************
    logic [15:0] coef_rd;
    ccfc_coef_bank u_coef (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (wr && sel_coef),
        .wr_idx    (ofs[5:2]),
        .wr_data   (wd),
        .rd_idx    (ofs[5:2]),
        .rd_data   (coef_rd),
        .coef_flat (coef_flat)
    );

    // ********************************
    // read data
    // ********************************
    logic [31:0] rdat;
    always_comb begin
        rdat = 32'h0000_0000;
        if (sel_ctl)   rdat = {24'h00_0000, ctl_q};
        if (sel_sr)    rdat = {27'h000_0000, sr_q[1], 3'h0, sr_q[0]};
        if (sel_coef)  rdat = {16'h0000, coef_rd};
        if (sel_istat) rdat = {30'h0000_0000, ist_q};
        if (sel_imask) rdat = {30'h0000_0000, imask_q};
    end
    // coefficient read data registered one cycle earlier in setup
    assign prdata = rd ? rdat : 32'h0000_0000;

    // ********************************
    // checks
    // ********************************
    a_mask_guard_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && !wd[BIT_SHORT_M]) |=> $stable(amp_input_short))
        else $error("input short changed without mask");
    a_mask_guard_take: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && wd[BIT_VOLTAGE_DIAG_ROUTE_M]) |=> voltage_diag_route == $past(wd[BIT_VOLTAGE_DIAG_ROUTE]))
        else $error("voltage route write lost");
    a_bg_reset_two: assert property (@(posedge pclk) $rose(presetn) |-> bandgap_select == BG_REF_TWO)
        else $error("bandgap select reset wrong");
    a_bytewise_refused: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && sel_ctl && pwrite && !full_half) |=> $stable(ctl_q))
        else $error("bytewise control write took effect");
    a_done_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (busy_q && offset_cal_finished) |=> sr_q[1])
        else $error("done flag not set");
    a_irq_gated_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_q[BIT_IRQEN] |-> !cal_irq)
        else $error("irq without enable");
    a_bit_one_zero: assert property (@(posedge pclk) disable iff (!presetn) ctl_q[1] == 1'b0)
        else $error("bit one not zero");
    a_start_no_relaunch: assert property (@(posedge pclk) disable iff (!presetn)
        (offset_cal_start && $past(offset_cal_start)) |-> !ocal_launch)
        else $error("held start relaunched");
    a_req_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        temp_out_of_range |=> sr_q[0])
        else $error("request flag not set");
    a_short_take: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && wd[BIT_SHORT_M]) |=> amp_input_short == $past(wd[BIT_SHORT]))
        else $error("input short write lost");
    a_current_route: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && wd[BIT_CURRENT_DIAG_ROUTE_M]) |=> current_diag_route == $past(wd[BIT_CURRENT_DIAG_ROUTE]))
        else $error("current route write lost");
    a_launch_busy: assert property (@(posedge pclk) disable iff (!presetn)
        ocal_launch |=> busy_q)
        else $error("calibration not launched");

    // ********************************
    // checks on masked writes and status
    // ********************************
    a_bg_mask_take: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && wd[BIT_BG_M_LO]) |=> bandgap_select[0] == $past(wd[BIT_BG_LO]))
        else $error("bandgap low bit write lost");
    a_bg_mask_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && !wd[BIT_BG_M_LO+1]) |=> $stable(bandgap_select[1]))
        else $error("bandgap high bit changed without mask");
    a_start_take: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && wd[BIT_OCAL_M]) |=> offset_cal_start == $past(wd[BIT_OCAL]))
        else $error("start bit write lost");
    a_start_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_wr |=> $stable(offset_cal_start))
        else $error("start bit changed without write");
    a_irqen_take: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && wd[BIT_IRQEN_M]) |=> ctl_q[BIT_IRQEN] == $past(wd[BIT_IRQEN]))
        else $error("irq enable write lost");
    a_irqen_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && !wd[BIT_IRQEN_M]) |=> $stable(ctl_q[BIT_IRQEN]))
        else $error("irq enable changed without mask");
    a_diag_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_wr && !wd[BIT_VOLTAGE_DIAG_ROUTE_M] && !wd[BIT_CURRENT_DIAG_ROUTE_M]) |=> $stable({voltage_diag_route, current_diag_route}))
        else $error("diag route changed without mask");
    a_cal_irq_on: assert property (@(posedge pclk) disable iff (!presetn)
        (temp_out_of_range && ctl_q[BIT_IRQEN] && !ctl_wr) |=> cal_irq)
        else $error("enabled calibration irq missing");
    a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && sel_sr && wd[BIT_DONE_F] && !sr_set[1]) |=> !sr_q[1])
        else $error("done flag not cleared");
    a_req_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && sel_sr && wd[BIT_CALREQ_F] && !temp_out_of_range) |=> !sr_q[0])
        else $error("request flag not cleared");
    a_done_needs_busy: assert property (@(posedge pclk) disable iff (!presetn)
        (offset_cal_finished && !busy_q && !sr_q[1]) |=> !sr_q[1])
        else $error("done flag set without calibration");
    a_ctl_read_masks: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && sel_ctl) |-> (prdata[31:8] == 24'h00_0000) && !prdata[1])
        else $error("control mask bits read nonzero");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && !mapped) |-> pslverr && (prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
endmodule // ccfc_top

/* File: ccfc_pkg.sv */
// package of offsets, field positions, reset values and encodings
// assumes apb with 32-bit data, one aligned word per register
package ccfc_pkg;
    localparam int          NUM_COEF      = 16;
    localparam int          COEF_W        = 16;
    localparam logic [11:0] BLOCK_BASE    = 12'h0200;
    localparam logic [11:0] NBLOCK_BASE   = 12'h0300;
    localparam logic [11:0] OFS_COMPENSATION_CONTROL  = 12'h00A0;
    localparam logic [11:0] OFS_COMP_SR   = 12'h00A2;
    localparam logic [11:0] OFS_COEF_BASE = 12'h0040;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h00B0;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h00B4;
    localparam logic [11:0] ADDR_COMPENSATION_CONTROL = 12'h00A0;
    localparam logic [11:0] ADDR_COMP_SR  = 12'h00A4;
    localparam int          BIT_BG_LO     = 6;
    localparam int          BIT_SHORT     = 5;
    localparam int          BIT_OCAL      = 4;
    localparam int          BIT_VOLTAGE_DIAG_ROUTE     = 3;
    localparam int          BIT_CURRENT_DIAG_ROUTE     = 2;
    localparam int          BIT_IRQEN     = 0;
    localparam int          BIT_BG_M_LO   = 14;
    localparam int          BIT_SHORT_M   = 13;
    localparam int          BIT_OCAL_M    = 12;
    localparam int          BIT_VOLTAGE_DIAG_ROUTE_M   = 11;
    localparam int          BIT_CURRENT_DIAG_ROUTE_M   = 10;
    localparam int          BIT_IRQEN_M   = 8;
    localparam int          BIT_DONE_F    = 4;
    localparam int          BIT_CALREQ_F  = 0;
    localparam logic [1:0]  BG_OFF        = 2'h0;
    localparam logic [1:0]  BG_REF_TWO    = 2'h2;
    localparam logic [7:0]  CTL_RESET     = 8'h80;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;
    localparam logic [COEF_W*NUM_COEF-1:0] COEF_RESET = {
        16'h0000, 16'h00F5, 16'h0312, 16'h051F, 16'h0852, 16'h0B44, 16'h0E35, 16'h1021,
        16'h10E5, 16'h1021, 16'h0E35, 16'h0B44, 16'h0852, 16'h051F, 16'h0312, 16'h00F5};
endpackage

/* File: ccfc_coef_bank.sv */
// sixteen filter coefficient words, sign-magnitude, registered read
// assumes writes and reads come from the apb slave on the same clock
`timescale 1ns/10ps
module ccfc_coef_bank #(
    parameter int N = ccfc_pkg::NUM_COEF,
    parameter int W = ccfc_pkg::COEF_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         wr_en,
    input  wire logic [3:0]   wr_idx,
    input  wire logic [W-1:0] wr_data,
    input  wire logic [3:0]   rd_idx,
    output logic      [W-1:0] rd_data,
    output logic      [W*N-1:0] coef_flat
);
    import ccfc_pkg::*;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_coef
            logic [W-1:0] coef_q;
            // msb sign, [14:0] magnitude
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    coef_q <= COEF_RESET[g*W +: W];
                end else if (wr_en && wr_idx == 4'(g)) begin
                    coef_q <= wr_data;
                end
            end
            assign coef_flat[g*W +: W] = coef_q;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= coef_flat[rd_idx*W +: W];
        end
    end

    a_coef_reset_peak: assert property (@(posedge pclk) $rose(presetn) |-> coef_flat[7*W +: W] == 16'h10E5)
        else $error("coefficient seven reset wrong");
endmodule // ccfc_coef_bank

/* File: ccfc_flag_unit.sv */
// sticky flags set by hardware, cleared by write one; set wins
// assumes events are single-cycle pulses on pclk
`timescale 1ns/10ps
module ccfc_flag_unit #(
    parameter int N = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] set_evt,
    input  wire logic [N-1:0] clr,
    output logic      [N-1:0] flag_q
);
    import ccfc_pkg::*;
    logic [N-1:0] flag_d;
    always_comb begin
        flag_d = (flag_q & ~clr) | set_evt;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end
    a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn) (|set_evt) |=> (|flag_q))
        else $error("flag event lost");
endmodule // ccfc_flag_unit

/* File: calib_control_and_filter_coefs_bench.sv */
// self-checking bench: apb master, analog pulses and a reference model
// assumes ccfc_pkg and the design files are compiled before this file
`timescale 1ns/10ps
module calib_control_and_filter_coefs_bench;
    import ccfc_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rdat;
    logic [3:0]    pstrb;
    logic          offset_cal_finished, temp_out_of_range, current_channel_enable;
    logic [1:0]    bandgap_select;
    logic          amp_input_short, offset_cal_start, voltage_diag_route, current_diag_route;
    logic          cal_irq, irq, rerr;
    logic [255:0]  coef_flat;
    logic [1:0]    m_bg;
    logic          m_sh, m_oc, m_dv, m_di, m_ie, m_done, m_req;
    logic [15:0]   m_coef [16];
    logic [31:0]   v;
    integer        seed, bad_count, checks_done, k;

    ccfc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .offset_cal_finished(offset_cal_finished),
        .temp_out_of_range(temp_out_of_range), .current_channel_enable(current_channel_enable),
        .bandgap_select(bandgap_select), .amp_input_short(amp_input_short),
        .offset_cal_start(offset_cal_start), .voltage_diag_route(voltage_diag_route),
        .current_diag_route(current_diag_route), .cal_irq(cal_irq), .irq(irq), .coef_flat(coef_flat));

    // ***************
    // clock and watchdog
    // ***************
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        bad_count = bad_count + 1;
        wrap_up();
    end

    // ***************
    // shared tasks
    // ***************
    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count = bad_count + 1;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) begin
            bad_count = bad_count + 1;
            wrap_up();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] mctl();
        return {24'h0, m_bg, m_sh, m_oc, m_dv, m_di, 1'b0, m_ie};
    endfunction
    task automatic ctl_chk(input logic [11:0] win);
        chk("ctl_pins", mctl() >> 2, {26'h0, bandgap_select, amp_input_short, offset_cal_start,
            voltage_diag_route, current_diag_route});
        apb(1'b0, win + OFS_COMPENSATION_CONTROL, 32'h0, 4'h0);
        chk("ctl_read", mctl(), rdat);
    endtask
    task automatic ctl_wr(input logic [11:0] win, input logic [15:0] d);
        apb(1'b1, win + OFS_COMPENSATION_CONTROL, {16'h0, d}, 4'hF);
        if (d[15]) m_bg[1] = d[7];
        if (d[14]) m_bg[0] = d[6];
        if (d[13]) m_sh = d[5];
        if (d[12]) m_oc = d[4];
        if (d[11]) m_dv = d[3];
        if (d[10]) m_di = d[2];
        if (d[8]) m_ie = d[0];
        ctl_chk(win ^ 12'h100);
    endtask
    task automatic pulse(input int which);
        if (which == 0) offset_cal_finished <= 1'b1;
        else temp_out_of_range <= 1'b1;
        @(posedge pclk);
        offset_cal_finished <= 1'b0;
        temp_out_of_range <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic st_chk();
        apb(1'b0, BLOCK_BASE + ADDR_COMP_SR, 32'h0, 4'h0);
        chk("status", {27'h0, m_done, 3'h0, m_req}, rdat);
    endtask

    // ***************
    // main sequence
    // ***************
    initial begin
        seed = 32'he59f;
        bad_count = 0;
        checks_done = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        presetn = 1'b0;
        offset_cal_finished = 1'b0;
        temp_out_of_range = 1'b0;
        current_channel_enable = 1'b0;
        m_bg = 2'h2;
        {m_sh, m_oc, m_dv, m_di, m_ie, m_done, m_req} = '0;
        m_coef = '{16'h00F5, 16'h0312, 16'h051F, 16'h0852, 16'h0B44, 16'h0E35, 16'h1021, 16'h10E5,
                   16'h1021, 16'h0E35, 16'h0B44, 16'h0852, 16'h051F, 16'h0312, 16'h00F5, 16'h0000};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 16; k++) begin
            apb(1'b0, NBLOCK_BASE + OFS_COEF_BASE + 12'(4 * k), 32'h0, 4'h0);
            chk("coef_reset", {16'h0, m_coef[k]}, rdat);
        end
        ctl_chk(BLOCK_BASE);
        for (k = 0; k < 4; k++) ctl_wr(BLOCK_BASE, {8'hC0, 2'(k), 6'h0});
        ctl_wr(NBLOCK_BASE, 16'h00FF);
        for (k = 0; k < 24; k++) begin
            v = $random(seed);
            ctl_wr(v[16] ? NBLOCK_BASE : BLOCK_BASE, v[15:0]);
        end
        apb(1'b1, BLOCK_BASE + OFS_COMPENSATION_CONTROL, 32'h0000_FFFD, 4'h1);
        chk("byte_err", 32'h1, {31'h0, rerr});
        ctl_chk(BLOCK_BASE);
        apb(1'b0, BLOCK_BASE + 12'h0FC, 32'h0, 4'h0);
        chk("unmapped_err", 32'h1, {31'h0, rerr});
        chk("unmapped_data", 32'h0, rdat);
        for (k = 0; k < 16; k += 5) begin
            v = $random(seed);
            m_coef[k] = {k[0], v[14:0]};
            apb(1'b1, BLOCK_BASE + OFS_COEF_BASE + 12'(4 * k), {16'h0, m_coef[k]}, 4'hF);
            apb(1'b0, NBLOCK_BASE + OFS_COEF_BASE + 12'(4 * k), 32'h0, 4'h0);
            chk("coef_rd", {16'h0, m_coef[k]}, rdat);
            chk("coef_pin", {16'h0, m_coef[k]}, {16'h0, coef_flat[16 * k +: 16]});
        end
        ctl_wr(BLOCK_BASE, 16'h3000);
        ctl_wr(BLOCK_BASE, 16'h3030);
        pulse(0);
        st_chk();
        current_channel_enable <= 1'b1;
        ctl_wr(BLOCK_BASE, 16'h3000);
        ctl_wr(BLOCK_BASE, 16'h3030);
        pulse(0);
        m_done = 1'b1;
        st_chk();
        ctl_chk(BLOCK_BASE);
        apb(1'b1, BLOCK_BASE + ADDR_COMP_SR, 32'h10, 4'hF);
        m_done = 1'b0;
        pulse(0);
        st_chk();
        ctl_wr(BLOCK_BASE, 16'h1000);
        ctl_wr(BLOCK_BASE, 16'h1010);
        pulse(0);
        m_done = 1'b1;
        st_chk();
        apb(1'b0, BLOCK_BASE + OFS_IRQ_STAT, 32'h0, 4'h0);
        chk("int_stat", 32'h2, rdat);
        apb(1'b1, BLOCK_BASE + OFS_IRQ_MASK, 32'h3, 4'hF);
        ctl_wr(BLOCK_BASE, 16'h0101);
        pulse(1);
        m_req = 1'b1;
        chk("irq_on", 32'h3, {30'h0, cal_irq, irq});
        st_chk();
        apb(1'b1, BLOCK_BASE + OFS_IRQ_MASK, 32'h0, 4'hF);
        chk("irq_masked", 32'h2, {30'h0, cal_irq, irq});
        apb(1'b1, BLOCK_BASE + OFS_IRQ_MASK, 32'h1, 4'hF);
        apb(1'b0, BLOCK_BASE + OFS_IRQ_STAT, 32'h0, 4'h0);
        chk("int_stat", 32'h1, rdat);
        apb(1'b0, BLOCK_BASE + OFS_IRQ_STAT, 32'h0, 4'h0);
        chk("int_clr", 32'h0, rdat);
        chk("irq_clr", 32'h2, {30'h0, cal_irq, irq});
        apb(1'b1, NBLOCK_BASE + ADDR_COMP_SR, 32'h11, 4'hF);
        m_req = 1'b0;
        m_done = 1'b0;
        st_chk();
        chk("cal_irq_w1c", 32'h0, {30'h0, cal_irq, irq});
        ctl_wr(BLOCK_BASE, 16'h0100);
        pulse(1);
        m_req = 1'b1;
        chk("irq_off", 32'h0, {30'h0, cal_irq, irq});
        st_chk();
        wrap_up();
    end
endmodule // calib_control_and_filter_coefs_bench
